// ==== rtl/dam_pkg.sv ====
// Package of constants, register map and types for the drive alarm manager.
package dam_pkg;
    // Clock and time base.
    localparam int CLK_PERIOD_PS = 5000;
    localparam int MS_PS = 1_000_000_000;
    localparam int TICK_CYC_DEF = MS_PS / CLK_PERIOD_PS;
    localparam int BLINK_HALF_MS = 200;
    localparam int BLINK_PAUSE_MS = 1000;
    localparam int BLINK_TIMES = 7;

    // Register byte offsets (word index is offset / 4).
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ERR_LIMIT = 8'h04;
    localparam logic [7:0] OFS_TIMEOUT = 8'h08;
    localparam logic [7:0] OFS_GEAR = 8'h0C;
    localparam logic [7:0] OFS_SOFT_MAX = 8'h10;
    localparam logic [7:0] OFS_SOFT_MIN = 8'h14;
    localparam logic [7:0] OFS_ALARM = 8'h18;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

    // Control register fields.
    localparam int CTRL_BRAKE_FITTED = 0;
    localparam int CTRL_SENSOR_INPUT_A_EN = 1;
    localparam int CTRL_TIM_EN = 2;
    localparam int CTRL_SOFT_EN = 3;
    localparam int CTRL_ALM_RESET = 4;
    localparam logic [3:0] CTRL_RESET = 4'h6;

    // Alarm register fields.
    localparam int ALM_ACTIVE = 8;
    localparam int ALM_CURRENT = 9;
    localparam int ALM_BRAKE = 10;

    // Interrupt bits.
    localparam int IRQ_RAISED = 0;
    localparam int IRQ_CLEARED = 1;

    // Reset values.
    localparam logic [7:0] ERR_LIMIT_RESET = 8'h03;
    localparam logic [15:0] TIMEOUT_RESET = 16'h0000;
    localparam logic [15:0] GEAR_RESET = 16'h03E8;
    localparam logic [31:0] SOFT_MAX_RESET = 32'h7FFF_FFFF;
    localparam logic [31:0] SOFT_MIN_RESET = 32'h8000_0000;

    // Limits.
    localparam logic [15:0] GEAR_MIN = 16'h0064;
    localparam logic [15:0] GEAR_MAX = 16'h2710;
    localparam logic [3:0] BAUD_MAX = 4'h4;

    // Alarm codes.
    localparam logic [7:0] CODE_NONE = 8'h00;
    localparam logic [7:0] CODE_HOME_SIG = 8'h64;
    localparam logic [7:0] CODE_SOFT_OT = 8'h67;
    localparam logic [7:0] CODE_GEAR = 8'h71;
    localparam logic [7:0] CODE_NET_BUS = 8'h81;
    localparam logic [7:0] CODE_BAUD_SW = 8'h83;
    localparam logic [7:0] CODE_COMM_ERR = 8'h84;
    localparam logic [7:0] CODE_COMM_TMO = 8'h85;
    localparam logic [7:0] CODE_CONV = 8'h8E;
    localparam logic [7:0] CODE_CPU = 8'hF0;

    typedef enum logic [1:0] {LAMP_IDLE, LAMP_ON, LAMP_OFF, LAMP_PAUSE} dam_lamp_t;
endpackage : dam_pkg

// ==== rtl/dam_top.sv ====
// Alarm manager of a stepping motor driver with an AHB-Lite register slave.
//
// Our own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module dam_top
    import dam_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYC_DEF,
    parameter int BLINK_CYC = BLINK_HALF_MS * TICK_CYC_DEF,
    parameter int PAUSE_CYC = BLINK_PAUSE_MS * TICK_CYC_DEF
)(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic alarm_clear_input,
    input wire logic [3:0] baud_select_switch,
    input wire logic sensor_input_a,
    input wire logic home_sensor_input,
    input wire logic conv_host_lost,
    input wire logic conv_alarm,
    input wire logic step_timing_output,
    input wire logic motor_running,
    input wire logic homing_active,
    input wire logic rx_frame_ok,
    input wire logic rx_frame_err,
    input wire logic move_load,
    input wire logic move_linked,
    input wire logic [31:0] move_base,
    input wire logic [31:0] move_delta,
    input wire logic cpu_fault,
    output logic motor_current_en,
    output logic brake_engage,
    output logic fault_lamp,
    output logic irq
);
    localparam int NPIN = 9;
    localparam int P_CLR = 0;
    localparam int P_SENSOR_INPUT_A = 1;
    localparam int P_HOME = 2;
    localparam int P_LOST = 3;
    localparam int P_CONV = 4;
    localparam int P_BAUD = 5;

    typedef struct packed {
        logic [NPIN-1:0] sync1;
        logic [NPIN-1:0] sync2;
        logic clr_prev;
        logic home_prev;
        logic seen;
        logic [7:0] err_cnt;
        logic [31:0] tick_cnt;
        logic [15:0] ms_cnt;
        logic [31:0] acc;
        logic [3:0] ctrl;
        logic [7:0] err_limit;
        logic [15:0] timeout;
        logic [15:0] gear;
        logic [31:0] soft_max;
        logic [31:0] soft_min;
        logic [7:0] code;
        logic active;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        dam_lamp_t lamp_st;
        logic [31:0] lamp_cnt;
        logic [3:0] blink_n;
        logic a_wr;
        logic [7:0] a_addr;
        logic [31:0] rdata;
        logic irq;
        logic lamp;
        logic cur_en;
        logic brake;
    } dam_state_t;

    dam_state_t st_ff;
    dam_state_t nxt_st;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st_ff.rdata;
    assign motor_current_en = st_ff.cur_en;
    assign brake_engage = st_ff.brake;
    assign fault_lamp = st_ff.lamp;
    assign irq = st_ff.irq;

    always_comb
    begin
        logic clr_fall;
        logic clr_cmd;
        logic tick;
        logic raise;
        logic [7:0] new_code;
        logic ev_raise;
        logic ev_clear;
        logic resettable;
        logic non_excite;
        logic home_hit;
        logic soft_hit;
        logic comm_hit;
        logic tmo_hit;
        logic [31:0] acc_n;
        logic [1:0] w1c;
        clr_fall = 1'b0;
        clr_cmd = 1'b0;
        tick = 1'b0;
        raise = 1'b0;
        new_code = CODE_NONE;
        ev_raise = 1'b0;
        ev_clear = 1'b0;
        resettable = 1'b0;
        non_excite = 1'b0;
        home_hit = 1'b0;
        soft_hit = 1'b0;
        comm_hit = 1'b0;
        tmo_hit = 1'b0;
        acc_n = st_ff.acc;
        w1c = 2'b00;
        nxt_st = st_ff;

        // Pins from outside the clock domain pass two flip-flops first.
        nxt_st.sync1 = {baud_select_switch, conv_alarm, conv_host_lost, home_sensor_input,
                        sensor_input_a, alarm_clear_input};
        nxt_st.sync2 = st_ff.sync1;

        // Register writes land in the data phase.
        if (st_ff.a_wr)
        begin
            case (st_ff.a_addr)
                OFS_CTRL:
                begin
                    nxt_st.ctrl = hwdata[3:0];
                    clr_cmd = hwdata[CTRL_ALM_RESET];
                end
                OFS_ERR_LIMIT: nxt_st.err_limit = hwdata[7:0];
                OFS_TIMEOUT: nxt_st.timeout = hwdata[15:0];
                OFS_GEAR: nxt_st.gear = hwdata[15:0];
                OFS_SOFT_MAX: nxt_st.soft_max = hwdata;
                OFS_SOFT_MIN: nxt_st.soft_min = hwdata;
                OFS_IRQ_STAT: w1c = hwdata[1:0];
                OFS_IRQ_MASK: nxt_st.irq_mask = hwdata[1:0];
                default: ;
            endcase
        end

        // Millisecond time base for the timeout counter.
        if (st_ff.tick_cnt == 32'(TICK_CYC - 1))
        begin
            nxt_st.tick_cnt = 32'h0000_0000;
            tick = 1'b1;
        end
        else
        begin
            nxt_st.tick_cnt = st_ff.tick_cnt + 32'h0000_0001;
        end

        // Consecutive error count; a good frame ends the run.
        if (rx_frame_ok)
        begin
            nxt_st.err_cnt = 8'h00;
        end
        else if (rx_frame_err && st_ff.err_cnt != 8'hFF)
        begin
            nxt_st.err_cnt = st_ff.err_cnt + 8'h01;
        end
        comm_hit = rx_frame_err && (st_ff.err_limit != 8'h00)
                   && (st_ff.err_cnt + 8'h01 >= st_ff.err_limit);

        // Timeout measured from the last good frame; zero disables it.
        if (rx_frame_ok)
        begin
            nxt_st.ms_cnt = 16'h0000;
        end
        else if (tick && st_ff.ms_cnt != 16'hFFFF)
        begin
            nxt_st.ms_cnt = st_ff.ms_cnt + 16'h0001;
        end
        tmo_hit = (st_ff.timeout != 16'h0000) && (st_ff.ms_cnt >= st_ff.timeout);

        // Home check: an enabled signal must be seen before home goes inactive.
        nxt_st.home_prev = st_ff.sync2[P_HOME];
        if (homing_active && st_ff.sync2[P_HOME])
        begin
            if ((st_ff.ctrl[CTRL_SENSOR_INPUT_A_EN] && st_ff.sync2[P_SENSOR_INPUT_A])
                || (st_ff.ctrl[CTRL_TIM_EN] && step_timing_output))
            begin
                nxt_st.seen = 1'b1;
            end
        end
        if (st_ff.home_prev && !st_ff.sync2[P_HOME])
        begin
            home_hit = homing_active && !st_ff.seen
                       && (st_ff.ctrl[CTRL_SENSOR_INPUT_A_EN] || st_ff.ctrl[CTRL_TIM_EN]);
            nxt_st.seen = 1'b0;
        end
        if (!homing_active)
        begin
            nxt_st.seen = 1'b0;
        end

        // Linked moves build on the accumulated target, not the current position.
        if (move_load)
        begin
            acc_n = (move_linked ? st_ff.acc : move_base) + move_delta;
            nxt_st.acc = acc_n;
            soft_hit = st_ff.ctrl[CTRL_SOFT_EN] && (($signed(acc_n) > $signed(st_ff.soft_max))
                       || ($signed(acc_n) < $signed(st_ff.soft_min)));
        end

        // Clear of resettable alarms by input fall or command.
        nxt_st.clr_prev = st_ff.sync2[P_CLR];
        clr_fall = st_ff.clr_prev && !st_ff.sync2[P_CLR];
        resettable = !(st_ff.code == CODE_BAUD_SW || st_ff.code == CODE_GEAR || st_ff.code == CODE_CPU);
        if (st_ff.active && resettable && (clr_fall || clr_cmd))
        begin
            nxt_st.active = 1'b0;
            nxt_st.code = CODE_NONE;
            nxt_st.err_cnt = 8'h00;
            nxt_st.ms_cnt = 16'h0000;
            ev_clear = 1'b1;
        end

        // Alarm detection in priority order; a CPU fault overrides any other alarm.
        raise = 1'b1;
        if (cpu_fault)
        begin
            new_code = CODE_CPU;
        end
        else if (st_ff.sync2[P_BAUD +: 4] > BAUD_MAX)
        begin
            new_code = CODE_BAUD_SW;
        end
        else if (st_ff.gear < GEAR_MIN || st_ff.gear > GEAR_MAX)
        begin
            new_code = CODE_GEAR;
        end
        else if (comm_hit)
        begin
            new_code = CODE_COMM_ERR;
        end
        else if (tmo_hit)
        begin
            new_code = CODE_COMM_TMO;
        end
        else if (motor_running && st_ff.sync2[P_LOST])
        begin
            new_code = CODE_NET_BUS;
        end
        else if (st_ff.sync2[P_CONV])
        begin
            new_code = CODE_CONV;
        end
        else if (home_hit)
        begin
            new_code = CODE_HOME_SIG;
        end
        else if (soft_hit)
        begin
            new_code = CODE_SOFT_OT;
        end
        else
        begin
            raise = 1'b0;
        end
        // A new alarm in the cycle of a clear wins, so no event is lost.
        if (raise && (!nxt_st.active || (new_code == CODE_CPU && st_ff.code != CODE_CPU)))
        begin
            nxt_st.active = 1'b1;
            nxt_st.code = new_code;
            ev_raise = 1'b1;
        end

        // Excitation follows the class of the latched alarm.
        non_excite = nxt_st.active && (nxt_st.code == CODE_BAUD_SW || nxt_st.code == CODE_GEAR
                     || nxt_st.code == CODE_CPU);
        nxt_st.cur_en = !non_excite;
        nxt_st.brake = non_excite && st_ff.ctrl[CTRL_BRAKE_FITTED];

        // Fault lamp: steady for CPU fault, groups of blinks otherwise.
        nxt_st.lamp = 1'b0;
        if (!nxt_st.active)
        begin
            nxt_st.lamp_st = LAMP_IDLE;
        end
        else if (nxt_st.code == CODE_CPU)
        begin
            nxt_st.lamp_st = LAMP_IDLE;
            nxt_st.lamp = 1'b1;
        end
        else
        begin
            nxt_st.lamp_cnt = st_ff.lamp_cnt - 32'h0000_0001;
            case (st_ff.lamp_st)
                LAMP_IDLE:
                begin
                    nxt_st.lamp_st = LAMP_ON;
                    nxt_st.lamp_cnt = 32'(BLINK_CYC);
                    nxt_st.blink_n = 4'h0;
                end
                LAMP_ON:
                begin
                    nxt_st.lamp = 1'b1;
                    if (st_ff.lamp_cnt == 32'h0000_0000)
                    begin
                        nxt_st.lamp_st = LAMP_OFF;
                        nxt_st.lamp = 1'b0;
                        nxt_st.lamp_cnt = 32'(BLINK_CYC);
                    end
                end
                LAMP_OFF:
                begin
                    if (st_ff.lamp_cnt == 32'h0000_0000)
                    begin
                        if (st_ff.blink_n == 4'(BLINK_TIMES - 1))
                        begin
                            nxt_st.lamp_st = LAMP_PAUSE;
                            nxt_st.lamp_cnt = 32'(PAUSE_CYC);
                            nxt_st.blink_n = 4'h0;
                        end
                        else
                        begin
                            nxt_st.lamp_st = LAMP_ON;
                            nxt_st.lamp_cnt = 32'(BLINK_CYC);
                            nxt_st.blink_n = st_ff.blink_n + 4'h1;
                        end
                    end
                end
                LAMP_PAUSE:
                begin
                    if (st_ff.lamp_cnt == 32'h0000_0000)
                    begin
                        nxt_st.lamp_st = LAMP_ON;
                        nxt_st.lamp_cnt = 32'(BLINK_CYC);
                    end
                end
                default: nxt_st.lamp_st = LAMP_IDLE;
            endcase
        end

        // Sticky interrupt bits; a new event beats a write-one clear.
        nxt_st.irq_stat[IRQ_RAISED] = (st_ff.irq_stat[IRQ_RAISED] & ~w1c[IRQ_RAISED]) | ev_raise;
        nxt_st.irq_stat[IRQ_CLEARED] = (st_ff.irq_stat[IRQ_CLEARED] & ~w1c[IRQ_CLEARED]) | ev_clear;
        nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);

        // Address phase; read data comes from the next state so a write just before is seen.
        nxt_st.a_wr = 1'b0;
        if (hsel && htrans[1] && hready)
        begin
            nxt_st.a_wr = hwrite;
            nxt_st.a_addr = haddr[7:0];
            if (!hwrite)
            begin
                case (haddr[7:0])
                    OFS_CTRL: nxt_st.rdata = {28'h000_0000, nxt_st.ctrl};
                    OFS_ERR_LIMIT: nxt_st.rdata = {24'h00_0000, nxt_st.err_limit};
                    OFS_TIMEOUT: nxt_st.rdata = {16'h0000, nxt_st.timeout};
                    OFS_GEAR: nxt_st.rdata = {16'h0000, nxt_st.gear};
                    OFS_SOFT_MAX: nxt_st.rdata = nxt_st.soft_max;
                    OFS_SOFT_MIN: nxt_st.rdata = nxt_st.soft_min;
                    OFS_ALARM: nxt_st.rdata = {21'h00_0000, nxt_st.brake, nxt_st.cur_en,
                                               nxt_st.active, nxt_st.code};
                    OFS_IRQ_STAT: nxt_st.rdata = {30'h0000_0000, nxt_st.irq_stat};
                    OFS_IRQ_MASK: nxt_st.rdata = {30'h0000_0000, nxt_st.irq_mask};
                    default: nxt_st.rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_ff <= '{sync1: '0, sync2: '0, clr_prev: 1'b0, home_prev: 1'b0, seen: 1'b0,
                       err_cnt: 8'h00, tick_cnt: 32'h0000_0000, ms_cnt: 16'h0000, acc: 32'h0000_0000,
                       ctrl: CTRL_RESET, err_limit: ERR_LIMIT_RESET, timeout: TIMEOUT_RESET,
                       gear: GEAR_RESET, soft_max: SOFT_MAX_RESET, soft_min: SOFT_MIN_RESET,
                       code: CODE_NONE, active: 1'b0, irq_stat: 2'b00, irq_mask: 2'b00,
                       lamp_st: LAMP_IDLE, lamp_cnt: 32'h0000_0000, blink_n: 4'h0, a_wr: 1'b0,
                       a_addr: 8'h00, rdata: 32'h0000_0000, irq: 1'b0, lamp: 1'b0, cur_en: 1'b1,
                       brake: 1'b0};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end
endmodule : dam_top

// ==== test/dam_host_model.sv ====
// Host controller model that sends good or corrupted serial frames.
`timescale 1ns/1ps
module dam_host_model (
    input wire logic hclk,
    output logic rx_frame_ok,
    output logic rx_frame_err
);
    initial
    begin
        rx_frame_ok = 1'b0;
        rx_frame_err = 1'b0;
    end

    // Each frame ends in a single-cycle verdict pulse and an idle gap, as a real link cannot repeat faster.
    task automatic send_frame(input logic bad);
        @(posedge hclk);
        rx_frame_ok <= !bad;
        rx_frame_err <= bad;
        @(posedge hclk);
        rx_frame_ok <= 1'b0;
        rx_frame_err <= 1'b0;
        repeat (2) @(posedge hclk);
    endtask : send_frame
endmodule : dam_host_model

// ==== test/dam_top_properties.sv ====
// Concurrent checks on the alarm manager top-level outputs.
`timescale 1ns/1ps
module dam_checker
    import dam_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [3:0] baud_select_switch,
    input wire logic conv_alarm,
    input wire logic conv_host_lost,
    input wire logic motor_running,
    input wire logic cpu_fault,
    input wire logic motor_current_en,
    input wire logic brake_engage,
    input wire logic fault_lamp
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_bus_zero_wait: assert property (hreadyout && !hresp)
        else $error("bus answer not zero-wait okay");
    a_cut_sticks: assert property (!motor_current_en |=> !motor_current_en)
        else $error("motor current back without reset");
    a_brake_when_cut: assert property (brake_engage |-> !motor_current_en)
        else $error("brake applied while energised");
    a_cpu_cuts_current: assert property ($rose(cpu_fault) |-> ##[1:3] !motor_current_en)
        else $error("cpu fault left current on");
    a_cpu_lamp_steady: assert property (cpu_fault [*4] |=> fault_lamp)
        else $error("lamp not steady on cpu fault");
    // A cpu fault turns the lamp steady, so the gap check stands aside then.
    a_lamp_off_gap: assert property (disable iff (!hresetn || cpu_fault) $fell(fault_lamp) |=> !fault_lamp [*3])
        else $error("lamp off phase too short");
    a_conv_keeps_on: assert property (conv_alarm && motor_current_en && !cpu_fault |=> motor_current_en)
        else $error("converter alarm cut current");
    a_net_keeps_on: assert property (conv_host_lost && motor_running && motor_current_en && !cpu_fault
        |=> motor_current_en)
        else $error("network alarm cut current");
    a_baud_cuts: assert property ((baud_select_switch > BAUD_MAX) [*4] |=> !motor_current_en)
        else $error("bad baud switch kept current");

    c_brake: cover property (brake_engage);
    c_blink: cover property ($fell(fault_lamp));
    c_cpu_lamp: cover property (cpu_fault && fault_lamp);
endmodule : dam_checker

bind dam_top dam_checker chk (
    .hclk, .hresetn, .hreadyout, .hresp, .baud_select_switch, .conv_alarm, .conv_host_lost,
    .motor_running, .cpu_fault, .motor_current_en, .brake_engage, .fault_lamp
);

// ==== test/drive_alarm_manager_tb.sv ====
// Self-checking testbench of the drive alarm manager.
`timescale 1ns/1ps
module drive_alarm_manager_tb;
    import dam_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp, irq;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
    logic alarm_clear_input = 1'b0, sensor_input_a = 1'b0, home_sensor_input = 1'b0;
    logic conv_host_lost = 1'b0, conv_alarm = 1'b0, step_timing_output = 1'b0, motor_running = 1'b0;
    logic homing_active = 1'b0, move_load = 1'b0, move_linked = 1'b0, cpu_fault = 1'b0;
    logic rx_frame_ok, rx_frame_err, motor_current_en, brake_engage, fault_lamp;
    logic [3:0] baud_select_switch = 4'h0;
    logic [31:0] move_base = 32'h0000_0000, move_delta = 32'h0000_0000, mbase;
    int err_count = 0, comparisons = 0, lim;

    assign hready = hreadyout;
    always #2.5 hclk = ~hclk;

    dam_top #(.TICK_CYC(10), .BLINK_CYC(4), .PAUSE_CYC(8)) dut (.*);
    dam_host_model host (.hclk(hclk), .rx_frame_ok(rx_frame_ok), .rx_frame_err(rx_frame_err));

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        @(posedge hclk);
        while (hready !== 1'b1)
            @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1)
            @(posedge hclk);
        rd = hrdata;
    endtask : ahb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask : rdchk

    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask : do_reset

    // Polls rather than waiting a fixed time, since timeout alarms take milliseconds.
    task automatic wait_alarm();
        int n;
        n = 0;
        ahb(1'b0, OFS_ALARM, 32'h0000_0000);
        while (rd[ALM_ACTIVE] !== 1'b1 && n < 60)
        begin
            ahb(1'b0, OFS_ALARM, 32'h0000_0000);
            n++;
        end
    endtask : wait_alarm

    task automatic expect_exc(input logic [7:0] code);
        wait_alarm();
        chk(rd, {22'h00_0000, 2'b11, code});
    endtask : expect_exc

    // The pause is the only low stretch of 8 samples or more, so two pauses frame one group of blinks.
    task automatic count_blinks();
        int low;
        int n;
        logic started;
        low = 0;
        n = 0;
        started = 1'b0;
        while (!(started && low >= 8))
        begin
            @(posedge hclk);
            if (fault_lamp === 1'b1)
            begin
                started = started || low >= 8;
                if (started && low > 0)
                    n++;
                low = 0;
            end
            else
                low++;
        end
        chk(n, BLINK_TIMES);
    endtask : count_blinks

    task automatic clear_alarm(input logic by_pin);
        if (by_pin)
        begin
            alarm_clear_input <= 1'b1;
            repeat (4) @(posedge hclk);
            alarm_clear_input <= 1'b0;
            repeat (6) @(posedge hclk);
        end
        else
            ahb(1'b1, OFS_CTRL, 32'h0000_0016);
    endtask : clear_alarm

    task automatic expect_clear(input logic by_pin);
        clear_alarm(by_pin);
        ahb(1'b0, OFS_ALARM, 32'h0000_0000);
        chk(rd & 32'h0000_0700, 32'h0000_0200);
    endtask : expect_clear

    task automatic move(input logic lk, input logic [31:0] d);
        move_load <= 1'b1;
        move_linked <= lk;
        move_base <= mbase;
        move_delta <= d;
        @(posedge hclk);
        move_load <= 1'b0;
        @(posedge hclk);
    endtask : move

    task automatic home_pass(input logic s, input logic t);
        home_sensor_input <= 1'b1;
        repeat (4) @(posedge hclk);
        sensor_input_a <= s;
        step_timing_output <= t;
        repeat (4) @(posedge hclk);
        sensor_input_a <= 1'b0;
        step_timing_output <= 1'b0;
        home_sensor_input <= 1'b0;
        repeat (6) @(posedge hclk);
    endtask : home_pass

    initial
    begin
        void'($urandom(32'ha6d3));
        do_reset();
        rdchk(OFS_CTRL, {28'h000_0000, CTRL_RESET});
        rdchk(OFS_GEAR, 32'h0000_03E8);
        rdchk(8'h40, 32'h0000_0000);
        rdchk(OFS_ALARM, 32'h0000_0200);
        ahb(1'b1, OFS_IRQ_MASK, 32'h0000_0003);
        lim = $urandom_range(5, 2);
        ahb(1'b1, OFS_ERR_LIMIT, lim);
        repeat (lim - 1) host.send_frame(1'b1);
        host.send_frame(1'b0);
        repeat (lim - 1) host.send_frame(1'b1);
        rdchk(OFS_ALARM, 32'h0000_0200);
        host.send_frame(1'b1);
        expect_exc(CODE_COMM_ERR);
        chk(irq, 1'b1);
        count_blinks();
        ahb(1'b1, OFS_IRQ_STAT, 32'h0000_0001);
        host.send_frame(1'b0);
        expect_clear(1'b1);
        rdchk(OFS_IRQ_STAT, 32'h0000_0002);
        ahb(1'b1, OFS_IRQ_MASK, 32'h0000_0000);
        repeat (2) @(posedge hclk);
        chk(irq, 1'b0);
        ahb(1'b1, OFS_IRQ_STAT, 32'h0000_0002);
        conv_alarm <= 1'b1;
        expect_exc(CODE_CONV);
        conv_alarm <= 1'b0;
        repeat (6) @(posedge hclk);
        rdchk(OFS_ALARM, 32'h0000_038E);
        expect_clear(1'b0);
        conv_host_lost <= 1'b1;
        repeat (6) @(posedge hclk);
        rdchk(OFS_ALARM, 32'h0000_0200);
        motor_running <= 1'b1;
        expect_exc(CODE_NET_BUS);
        conv_host_lost <= 1'b0;
        motor_running <= 1'b0;
        repeat (4) @(posedge hclk);
        expect_clear(1'b1);
        host.send_frame(1'b0);
        ahb(1'b1, OFS_TIMEOUT, 32'h0000_0002);
        rdchk(OFS_ALARM, 32'h0000_0200);
        expect_exc(CODE_COMM_TMO);
        ahb(1'b1, OFS_TIMEOUT, 32'h0000_0000);
        expect_clear(1'b0);
        mbase = $urandom_range(50000, 0);
        ahb(1'b1, OFS_SOFT_MAX, mbase + 32'h0000_0190);
        ahb(1'b1, OFS_CTRL, 32'h0000_000E);
        move(1'b0, 32'h0000_012C);
        move(1'b1, 32'h0000_0064);
        rdchk(OFS_ALARM, 32'h0000_0200);
        move(1'b1, 32'h0000_0001);
        expect_exc(CODE_SOFT_OT);
        expect_clear(1'b0);
        homing_active <= 1'b1;
        home_pass(1'b1, 1'b0);
        rdchk(OFS_ALARM, 32'h0000_0200);
        ahb(1'b1, OFS_CTRL, 32'h0000_0004);
        home_pass(1'b1, 1'b0);
        expect_exc(CODE_HOME_SIG);
        expect_clear(1'b1);
        home_pass(1'b0, 1'b1);
        rdchk(OFS_ALARM, 32'h0000_0200);
        ahb(1'b1, OFS_CTRL, 32'h0000_0002);
        home_pass(1'b0, 1'b1);
        expect_exc(CODE_HOME_SIG);
        expect_clear(1'b1);
        ahb(1'b1, OFS_CTRL, 32'h0000_0000);
        home_pass(1'b0, 1'b0);
        rdchk(OFS_ALARM, 32'h0000_0200);
        homing_active <= 1'b0;
        ahb(1'b1, OFS_CTRL, 32'h0000_0007);
        ahb(1'b1, OFS_GEAR, $urandom_range(10000, 100));
        rdchk(OFS_ALARM, 32'h0000_0200);
        ahb(1'b1, OFS_GEAR, 32'h0000_2711);
        wait_alarm();
        chk(rd, 32'h0000_0571);
        chk({brake_engage, motor_current_en}, 2'b10);
        clear_alarm(1'b1);
        rdchk(OFS_ALARM, 32'h0000_0571);
        baud_select_switch <= $urandom_range(15, 5);
        do_reset();
        wait_alarm();
        chk(rd, 32'h0000_0183);
        clear_alarm(1'b0);
        rdchk(OFS_ALARM, 32'h0000_0183);
        baud_select_switch <= 4'h0;
        do_reset();
        conv_alarm <= 1'b1;
        expect_exc(CODE_CONV);
        cpu_fault <= 1'b1;
        repeat (20) @(posedge hclk);
        rdchk(OFS_ALARM, 32'h0000_01F0);
        chk(fault_lamp, 1'b1);
        clear_alarm(1'b1);
        rdchk(OFS_ALARM, 32'h0000_01F0);
        cpu_fault <= 1'b0;
        conv_alarm <= 1'b0;
        do_reset();
        rdchk(OFS_ALARM, 32'h0000_0200);
        test_done();
    end

    // The sequence needs a few hundred cycles; 40,000 leaves ample margin.
    initial
    begin
        #200000;
        err_count++;
        test_done();
    end
endmodule : drive_alarm_manager_tb
